// ### dv/flag_core_chk.sv
// Port-level checker of the flag core: timing, bank mapping and flag forcing.
`timescale 1ns/1ps
module flag_core_chk #(
	parameter int CLOCKS_PER_MC = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic fetch_strobe,
	input wire logic machine_cycle_end,
	input wire logic busy,
	input wire logic [4:0] bank_base,
	input wire flag_core_pkg::byte_t status_word
);
	import flag_core_pkg::*;
	logic cmd_ph_r;
	logic sw_ph_r;
	byte_t cmd_r;
	wire take = hsel && hready && htrans[1] && hwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// The opcode is held only once accepted, since a command written while busy is dropped.
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_ph_r <= 1'b0;
			sw_ph_r <= 1'b0;
			cmd_r <= 8'h00;
		end else begin
			cmd_ph_r <= take && haddr == 32'h0;
			sw_ph_r <= take && haddr == 32'hd0;
			if (cmd_ph_r && !busy) begin
				cmd_r <= hwdata[7:0];
			end
		end
	end
	property p_mc_len;
		machine_cycle_end |=> !machine_cycle_end [*3];
	endproperty
	a_mc_len: assert property (p_mc_len) else $error("machine cycle shorter than four clocks");
	property p_fetch_end;
		fetch_strobe |-> ##3 machine_cycle_end;
	endproperty
	a_fetch_end: assert property (p_fetch_end) else $error("fetch not followed by cycle end");
	property p_one_fetch;
		fetch_strobe |=> !fetch_strobe [*3];
	endproperty
	a_one_fetch: assert property (p_one_fetch) else $error("two fetches in one machine cycle");
	property p_first_fetch;
		$rose(busy) |-> fetch_strobe;
	endproperty
	a_first_fetch: assert property (p_first_fetch) else $error("no fetch at instruction start");
	property p_short;
		$rose(busy) && cmd_r inside {8'h00, 8'h26, 8'h28} |-> busy [*4] ##1 !busy;
	endproperty
	a_short: assert property (p_short) else $error("one-byte instruction not one cycle");
	property p_bank;
		bank_base == {status_word[4:3], 3'b000};
	endproperty
	a_bank: assert property (p_bank) else $error("bank base mismatch");
	property p_user;
		$changed(status_word[5]) || $changed(status_word[1]) |-> $past(sw_ph_r);
	endproperty
	a_user: assert property (p_user) else $error("user flag changed without a write");
	property p_carry_force;
		$fell(busy) && (cmd_r == 8'hd3 || cmd_r == 8'hc3) |-> status_word[7] == (cmd_r == 8'hd3);
	endproperty
	a_carry_force: assert property (p_carry_force) else $error("carry not forced");
	property p_muldiv;
		$fell(busy) && (cmd_r == 8'ha4 || cmd_r == 8'h84) |-> !status_word[7];
	endproperty
	a_muldiv: assert property (p_muldiv) else $error("carry not cleared by multiply");
	c_short: cover property ($rose(busy) && cmd_r == 8'h28);
	c_setb: cover property ($fell(busy) && cmd_r == 8'hd3);
	c_bank3: cover property (bank_base == 5'h18);
endmodule
bind flag_core flag_core_chk #(.CLOCKS_PER_MC(CLOCKS_PER_MC)) flag_core_chk_i (.clk, .srst, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .fetch_strobe, .machine_cycle_end, .busy, .bank_base, .status_word);

// ### dv/tb_top.sv
// Self-checking bench of the flag core driven over its register bus.
`timescale 1ns/1ps
`include "flag_core_defs.svh"
module tb_top;
	import flag_core_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic hready;
	logic fetch_strobe;
	logic mce;
	logic hresp;
	logic busy;
	logic [4:0] bank_base;
	byte_t status_word;
	int miscompares = 0;
	int comparisons = 0;
	int cyc = 0;
	byte_t ops[6] = '{8'h00, 8'h02, 8'h01, 8'hb4, 8'h25, 8'h11};
	int clks[6] = '{4, 16, 12, 16, 8, 12};
	int fets[6] = '{1, 3, 2, 3, 2, 2};
	always #25 clk = ~clk;
	flag_core flag_core_i (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.fetch_strobe(fetch_strobe), .machine_cycle_end(mce), .busy(busy), .bank_base(bank_base),
		.status_word(status_word));
	task final_report;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Read data is taken at the edge that ends the data phase, before that edge's updates land.
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task exec(input byte_t op, input byte_t a, input int clocks, input int fetches);
		int n;
		int f;
		int m;
		n = 0;
		f = 0;
		m = 0;
		bus(1'b1, `OFF_CMD, {16'h0, a, op});
		#1;
		while (busy === 1'b1 && n < 64) begin
			if (fetch_strobe === 1'b1) begin
				f++;
			end
			if (mce === 1'b1) begin
				m++;
			end
			n++;
			@(posedge clk);
			#1;
		end
		chk(n, clocks);
		chk(m, clocks / 4);
		chk(f, fetches);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			final_report;
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, 32'hd0 + 32'h10 * i, 32'h0);
			chk(rd, 32'h0);
		end
		bus(1'b1, `OFF_MAIN_OPERAND, 32'h07);
		bus(1'b0, `OFF_STATUS_WORD, 32'h0);
		chk(rd, 32'h01);
		$display("test reset and parity done");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, `OFF_STATUS_WORD, 32'h22 | (i << 3));
			bus(1'b0, `OFF_STATUS_WORD, 32'h0);
			chk(rd, 32'h23 | (i << 3));
			chk(bank_base, i * 8);
		end
		bus(1'b1, `OFF_STATUS_WORD, 32'h0);
		$display("test banks and user flags done");
		bus(1'b1, `OFF_MAIN_OPERAND, 32'h7f);
		exec(8'h24, 8'h01, 8, 2);
		bus(1'b0, `OFF_STATUS_WORD, 32'h0);
		chk(rd, 32'h45);
		exec(8'h28, 8'h80, 4, 1);
		bus(1'b0, `OFF_STATUS_WORD, 32'h0);
		chk(rd, 32'h84);
		$display("test add flags done");
		bus(1'b1, `OFF_SECOND_OPERAND, 32'h20);
		bus(1'b1, `OFF_MAIN_OPERAND, 32'h10);
		exec(8'ha4, 8'h00, 4, 1);
		bus(1'b0, `OFF_STATUS_WORD, 32'h0);
		chk(rd, 32'h04);
		bus(1'b0, `OFF_SECOND_OPERAND, 32'h0);
		chk(rd, 32'h02);
		for (int i = 0; i < 2; i++) begin
			exec(i == 0 ? 8'hd3 : 8'hc3, 8'h00, 4, 1);
			bus(1'b0, `OFF_STATUS_WORD, 32'h0);
			chk(rd, i == 0 ? 32'h84 : 32'h04);
		end
		$display("test multiply and carry done");
		for (int i = 0; i < 6; i++) begin
			exec(ops[i], 8'h00, clks[i], fets[i]);
		end
		bus(1'b1, 32'h40, 32'hff);
		bus(1'b0, 32'h40, 32'h0);
		chk(rd, 32'h0);
		$display("test timing and unmapped done");
		exec(8'hd3, 8'h00, 4, 1);
		exec(8'h94, 8'h01, 8, 2);
		bus(1'b0, `OFF_STATUS_WORD, 32'h0);
		chk(rd, 32'hc1);
		exec(8'h13, 8'h00, 4, 1);
		bus(1'b0, `OFF_STATUS_WORD, 32'h0);
		chk(rd, 32'h40);
		bus(1'b0, `OFF_MAIN_OPERAND, 32'h0);
		chk(rd, 32'hff);
		exec(8'h84, 8'h00, 4, 1);
		bus(1'b0, `OFF_STATUS_WORD, 32'h0);
		chk(rd, 32'h41);
		bus(1'b0, `OFF_SECOND_OPERAND, 32'h0);
		chk(rd, 32'h01);
		exec(8'h72, 8'h01, 8, 2);
		bus(1'b0, `OFF_STATUS_WORD, 32'h0);
		chk(rd, 32'hc1);
		exec(8'hb3, 8'h00, 4, 1);
		bus(1'b0, `OFF_STATUS_WORD, 32'h0);
		chk(rd, 32'h41);
		bus(1'b0, `OFF_TIMING, 32'h0);
		chk(rd, 32'h24);
		chk({31'h0, hresp}, 32'h0);
		$display("test subtract divide and bit ops done");
		final_report;
	end
endmodule

// ### verilog/flag_core.sv
// Program status flags, operand registers and machine-cycle timing of the 8-bit core, on AHB-Lite.
`timescale 1ns/1ps
`include "flag_core_defs.svh"

module flag_core #(
	parameter int CLOCKS_PER_MC = `CLOCKS_PER_MACHINE_CYCLE
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic fetch_strobe,
	output logic machine_cycle_end,
	output logic busy,
	output logic [4:0] bank_base,
	output flag_core_pkg::byte_t status_word
);
	import flag_core_pkg::*;

	localparam int PW = $clog2(CLOCKS_PER_MC);

	initial begin
		if (CLOCKS_PER_MC != 4) begin
			$error("flag_core: a machine cycle must be four clocks");
		end
	end

	run_state_t state_r;
	logic [PW-1:0] phase_r;
	logic [2:0] mc_r;
	logic [1:0] bytes_r;
	logic [2:0] cycles_r;
	logic [2:0] last_cycles_r;
	byte_t opcode_r;
	byte_t op1_r;
	byte_t op2_r;
	byte_t acc_r;
	byte_t b_r;
	logic cy_r, ac_r, ov_r, f0_r, f1_r, rs1_r, rs0_r, par_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;

	// Bus slave: zero wait states, so every transfer completes in its first data-phase cycle.
	wire addr_phase = hsel & hready & htrans[1];
	wire [7:0] a_off = haddr[7:0];
	wire a_hit_cmd = haddr[31:8] == 24'h000000 && a_off == `OFF_CMD;
	wire a_hit_tim = haddr[31:8] == 24'h000000 && a_off == `OFF_TIMING;
	wire a_hit_sw = haddr[31:8] == 24'h000000 && a_off == `OFF_STATUS_WORD;
	wire a_hit_acc = haddr[31:8] == 24'h000000 && a_off == `OFF_MAIN_OPERAND;
	wire a_hit_b = haddr[31:8] == 24'h000000 && a_off == `OFF_SECOND_OPERAND;
	wire wr_cmd = wr_pend_r && wr_addr_r == `OFF_CMD;
	wire wr_sw = wr_pend_r && wr_addr_r == `OFF_STATUS_WORD;
	wire wr_acc = wr_pend_r && wr_addr_r == `OFF_MAIN_OPERAND;
	wire wr_b = wr_pend_r && wr_addr_r == `OFF_SECOND_OPERAND;

	wire byte_t sw_now = {cy_r, ac_r, f0_r, rs1_r, rs0_r, ov_r, f1_r, par_r};
	wire [31:0] tim_word = {24'h000000, last_cycles_r, mc_r, 1'b0, state_r == ST_RUN};
	wire [31:0] rd_word = a_hit_cmd ? {8'h00, op2_r, op1_r, opcode_r} :
		a_hit_tim ? tim_word :
		a_hit_sw ? {24'h000000, sw_now} :
		a_hit_acc ? {24'h000000, acc_r} :
		a_hit_b ? {24'h000000, b_r} : 32'h00000000;

	// Length decode: bytes in [4:3], machine cycles in [2:0].
	function automatic logic [4:0] decode_len(input byte_t op);
		logic jump;
		logic [1:0] nb;
		// Both the absolute jump and the absolute call end in 1, whichever their upper nibble.
		jump = op[3:0] == 4'h1 || op == 8'h02 || op == 8'h12 || op == 8'h80 || op[7:4] == 4'hb && op[3:2] != 2'b00;
		nb = 2'd1;
		if (op[3:0] == 4'h1 || op == 8'h80 || op == 8'h24 || op == 8'h25 || op == 8'h34 || op == 8'h35 ||
			op == 8'h94 || op == 8'h95 || op == 8'h54 || op == 8'h55 || op == 8'h52 || op == 8'h82 ||
			op == 8'hb0 || op == 8'h72 || op == 8'ha0 || op == 8'ha2) begin
			nb = 2'd2;
		end else if (op == 8'h02 || op == 8'h12 || op == 8'h53 || op[7:4] == 4'hb && op[3:2] != 2'b00) begin
			nb = 2'd3;
		end
		decode_len = {nb, 1'b0, nb} + {4'h0, jump};
	endfunction

	wire [4:0] len = decode_len(hwdata[7:0]);
	wire launch = wr_cmd && state_r == ST_IDLE;
	wire phase_last = phase_r == PW'(CLOCKS_PER_MC - 1);
	wire commit = state_r == ST_RUN && phase_last && mc_r == cycles_r - 3'd1;

	// Operation classes.
	wire is_add = opcode_r[7:4] == 4'h2 && opcode_r[3:2] != 2'b00;
	wire is_addc = opcode_r[7:4] == 4'h3 && opcode_r[3:2] != 2'b00;
	wire is_subb = opcode_r[7:4] == 4'h9 && opcode_r[3:2] != 2'b00;
	wire is_mul = opcode_r == 8'ha4;
	wire is_div = opcode_r == 8'h84;
	wire is_da = opcode_r == 8'hd4;
	wire is_rrc = opcode_r == 8'h13;
	wire is_rlc = opcode_r == 8'h33;
	wire is_cjne = opcode_r[7:4] == 4'hb && opcode_r[3:2] != 2'b00;
	wire bit_in = op1_r[0];

	// Adder shared by add, add-with-carry and subtract; subtract adds the complement.
	wire cin = is_addc ? cy_r : (is_subb ? ~cy_r : 1'b0);
	wire byte_t src = is_subb ? ~op1_r : op1_r;
	wire [4:0] lo_sum = {1'b0, acc_r[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
	wire [7:0] b6_sum = {1'b0, acc_r[6:0]} + {1'b0, src[6:0]} + {7'h00, cin};
	wire [8:0] full_sum = {1'b0, acc_r} + {1'b0, src} + {8'h00, cin};
	// A subtract borrow is the inverted carry of the complement add.
	wire ar_cy = is_subb ? ~full_sum[8] : full_sum[8];
	wire ar_ac = is_subb ? ~lo_sum[4] : lo_sum[4];
	wire ar_ov = full_sum[8] ^ b6_sum[7];

	wire [15:0] product = acc_r * b_r;
	wire byte_t quot = b_r == 8'h00 ? acc_r : acc_r / b_r;
	wire byte_t remd = b_r == 8'h00 ? b_r : acc_r % b_r;

	wire da_lo = acc_r[3:0] > 4'h9 || ac_r;
	wire [8:0] da_step = {1'b0, acc_r} + (da_lo ? 9'h006 : 9'h000);
	wire da_hi = da_step[8] || cy_r || da_step[7:4] > 4'h9;
	wire [8:0] da_res = da_step + (da_hi ? 9'h060 : 9'h000);

	wire byte_t cmp_a = opcode_r[3:1] == 3'b010 ? acc_r : op1_r;
	wire byte_t cmp_b = opcode_r[3:1] == 3'b010 ? op1_r : op2_r;

	// Result of the instruction, applied only at the end of its last machine cycle.
	byte_t acc_res, b_res;
	logic cy_res, ac_res, ov_res;
	always_comb begin
		acc_res = acc_r;
		b_res = b_r;
		cy_res = cy_r;
		ac_res = ac_r;
		ov_res = ov_r;
		if (is_add || is_addc || is_subb) begin
			acc_res = full_sum[7:0];
			cy_res = ar_cy;
			ac_res = ar_ac;
			ov_res = ar_ov;
		end else if (is_mul) begin
			acc_res = product[7:0];
			b_res = product[15:8];
			cy_res = 1'b0;
			ov_res = product[15:8] != 8'h00;
		end else if (is_div) begin
			// Divide by zero leaves both operands as they were and flags the wrap.
			acc_res = quot;
			b_res = remd;
			cy_res = 1'b0;
			ov_res = b_r == 8'h00;
		end else if (is_da) begin
			acc_res = da_res[7:0];
			cy_res = cy_r | da_res[8] | da_hi;
		end else if (is_rrc) begin
			acc_res = {cy_r, acc_r[7:1]};
			cy_res = acc_r[0];
		end else if (is_rlc) begin
			acc_res = {acc_r[6:0], cy_r};
			cy_res = acc_r[7];
		end else if (is_cjne) begin
			cy_res = cmp_a < cmp_b;
		end else if (opcode_r == 8'hd3) begin
			cy_res = 1'b1;
		end else if (opcode_r == 8'hc3) begin
			cy_res = 1'b0;
		end else if (opcode_r == 8'hb3) begin
			cy_res = ~cy_r;
		end else if (opcode_r == 8'h82) begin
			cy_res = cy_r & bit_in;
		end else if (opcode_r == 8'hb0) begin
			cy_res = cy_r & ~bit_in;
		end else if (opcode_r == 8'h72) begin
			cy_res = cy_r | bit_in;
		end else if (opcode_r == 8'ha0) begin
			cy_res = cy_r | ~bit_in;
		end else if (opcode_r == 8'ha2) begin
			cy_res = bit_in;
		end
	end

	// A finishing instruction wins over a bus write to the same register in the same cycle.
	wire byte_t acc_nxt = commit ? acc_res : (wr_acc ? hwdata[7:0] : acc_r);
	wire byte_t b_nxt = commit ? b_res : (wr_b ? hwdata[7:0] : b_r);
	wire cy_nxt = commit ? cy_res : (wr_sw ? hwdata[`SW_CARRY] : cy_r);
	wire ac_nxt = commit ? ac_res : (wr_sw ? hwdata[`SW_HALF_CARRY] : ac_r);
	wire ov_nxt = commit ? ov_res : (wr_sw ? hwdata[`SW_SIGNED_WRAP] : ov_r);
	wire [PW-1:0] phase_nxt = state_r == ST_RUN && !phase_last ? phase_r + PW'(1) : '0;
	wire [2:0] mc_nxt = launch ? 3'd0 : (state_r == ST_RUN && phase_last ? mc_r + 3'd1 : mc_r);

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			wr_pend_r <= addr_phase & hwrite;
			wr_addr_r <= a_off;
			if (addr_phase && !hwrite) begin
				hrdata <= rd_word;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= ST_IDLE;
			phase_r <= '0;
			mc_r <= 3'd0;
			bytes_r <= 2'd0;
			cycles_r <= 3'd0;
			last_cycles_r <= 3'd0;
			opcode_r <= 8'h00;
			op1_r <= 8'h00;
			op2_r <= 8'h00;
		end else begin
			phase_r <= phase_nxt;
			mc_r <= mc_nxt;
			if (launch) begin
				state_r <= ST_RUN;
				opcode_r <= hwdata[7:0];
				op1_r <= hwdata[15:8];
				op2_r <= hwdata[23:16];
				bytes_r <= len[4:3];
				cycles_r <= len[2:0];
			end else if (commit) begin
				state_r <= ST_IDLE;
				last_cycles_r <= cycles_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			acc_r <= `RST_MAIN_OPERAND;
			b_r <= `RST_SECOND_OPERAND;
			{cy_r, ac_r, f0_r, rs1_r, rs0_r, ov_r, f1_r, par_r} <= `RST_STATUS_WORD;
		end else begin
			acc_r <= acc_nxt;
			b_r <= b_nxt;
			cy_r <= cy_nxt;
			ac_r <= ac_nxt;
			ov_r <= ov_nxt;
			par_r <= ^acc_nxt;
			if (wr_sw) begin
				f0_r <= hwdata[`SW_USER_ZERO];
				f1_r <= hwdata[`SW_USER_ONE];
				rs1_r <= hwdata[`SW_BANK_HIGH];
				rs0_r <= hwdata[`SW_BANK_LOW];
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign busy = state_r == ST_RUN;
	assign fetch_strobe = state_r == ST_RUN && phase_r == '0 && mc_r < {1'b0, bytes_r};
	assign machine_cycle_end = state_r == ST_RUN && phase_last;
	assign bank_base = 5'({rs1_r, rs0_r}) << `BANK_SPAN_SHIFT;
	assign status_word = sw_now;
endmodule

// ### verilog/flag_core_defs.svh
// Register offsets, field positions, reset values and timing counts of the flag and timing core.
`ifndef FLAG_CORE_DEFS_SVH
`define FLAG_CORE_DEFS_SVH
`define OFF_CMD 8'h00
`define OFF_TIMING 8'h04
`define OFF_STATUS_WORD 8'hd0
`define OFF_MAIN_OPERAND 8'he0
`define OFF_SECOND_OPERAND 8'hf0
`define SW_CARRY 7
`define SW_HALF_CARRY 6
`define SW_USER_ZERO 5
`define SW_BANK_HIGH 4
`define SW_BANK_LOW 3
`define SW_SIGNED_WRAP 2
`define SW_USER_ONE 1
`define SW_ODD_ONES 0
`define RST_STATUS_WORD 8'h00
`define RST_MAIN_OPERAND 8'h00
`define RST_SECOND_OPERAND 8'h00
`define CLOCKS_PER_MACHINE_CYCLE 4
`define BANK_SPAN_SHIFT 3
`endif

// ### verilog/flag_core_pkg.sv
// Types shared by the flag and timing core.
package flag_core_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} run_state_t;
	typedef logic [7:0] byte_t;
endpackage
